// ### rtl/chip_reset_pin_control.sv
// Purpose: Chip reset sequencing from the reset pin and power-on reset
// Assumes: Pin inputs synchronous to ref_clk; rst is the power-on reset
// Notes:
// Notes on behaviour
// - Reset pin low initialises logic and holds the chip in reset.
// - On reset pin release, latch boot selection pin as operating mode.
// - Internal reset deasserts synchronously after a fixed clock count.
// - Pin reset alone resets the core but leaves debug logic untouched.
// - Power-on reset asserts internal reset regardless of the pin.
// - Reset output pin always reflects the internal reset state.
// - Pull-up on unless disable bit set, in reset or not; forced on during power-on reset.
// - Boot externally when latched selection high and flash not secured.
`timescale 1ns/100ps
`default_nettype none

module chip_reset_pin_control
(
   // Clock and power-on reset
   input wire logic ref_clk,
   input wire logic rst,
   // Board pins
   input wire logic reset_pin_n,
   input wire logic test_reset_n,
   input wire logic boot_select_pin,
   // Configuration
   input wire logic pullup_disable_reg,
   input wire logic flash_secured,
   // Outputs
   output var logic reset_out_pin,
   output var logic reset_pullup_en,
   output var logic boot_external,
   output var reset_ctl_pkg::reset_status_s status
);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state and release counter
   reset_ctl_pkg::seq_state_e state_q, state_d;
   logic [7:0] count_q, count_d;
   // Boot selection level latched at pin release
   logic mode_q, mode_d;
   // Next values of the registered outputs
   logic core_reset_d;
   logic pullup_d;
   logic boot_ext_d;
   reset_ctl_pkg::reset_status_s status_d;
   wire pin_active;
   wire count_done;

   ////////////////////////////////////////////////////////////////////////
   // True on the last count value; the release edge follows it
   function automatic logic is_last_count(input logic [7:0] value);
      return value == reset_ctl_pkg::release_cycles - 8'h01;
   endfunction

   // Boot from off-chip memory only if selected and flash not secured
   function automatic logic boot_from_outside(input logic sel,
                                               input logic secured);
      return sel & ~secured;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin reset is active low; the pin is taken as already synchronous,
   // so a glitch shorter than one clock may be missed
   assign pin_active = ~reset_pin_n;
   assign count_done = is_last_count(count_q);

   // Sequencer: hold while pin low, count after release, then run
   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      mode_d = mode_q;
      case (state_q)
         reset_ctl_pkg::st_hold:
         begin
            count_d = reset_ctl_pkg::count_reset_val;
            if (!pin_active)
            begin
               mode_d = boot_select_pin;
               state_d = reset_ctl_pkg::st_count;
            end
         end
         reset_ctl_pkg::st_count:
         begin
            count_d = count_q + 8'h01;
            if (count_done)
            begin
               state_d = reset_ctl_pkg::st_run;
            end
         end
         reset_ctl_pkg::st_run:
         begin
            state_d = reset_ctl_pkg::st_run;
         end
         default:
         begin
            state_d = reset_ctl_pkg::st_hold;
         end
      endcase
      // A new pin assertion restarts the whole sequence
      if (pin_active)
      begin
         state_d = reset_ctl_pkg::st_hold;
         count_d = reset_ctl_pkg::count_reset_val;
      end
   end

   // Next values of the registered outputs
   assign core_reset_d = (state_d != reset_ctl_pkg::st_run);
   assign pullup_d = ~pullup_disable_reg;
   assign boot_ext_d = boot_from_outside(mode_d, flash_secured);
   // Debug follows only the test-port reset, so a pin reset spares it
   assign status_d = '{core_reset_d,
                       ~test_reset_n,
                       reset_ctl_pkg::boot_mode_e'(boot_ext_d)};

   ////////////////////////////////////////////////////////////////////////
   // Every register resets asynchronously on power-on reset; the pin reset
   // acts through the sequencer only, so it takes effect at the next edge
   // Sequencer state; power-on reset forces the hold state
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= reset_ctl_pkg::st_hold;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Release counter; power-on reset restarts it from zero
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         count_q <= reset_ctl_pkg::count_reset_val;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // Latched boot selection; cleared on power-on reset, then loaded from
   // boot_select_pin at the first edge in hold with the pin high, even without a pin release
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         mode_q <= reset_ctl_pkg::mode_reset_val;
      end
      else
      begin
         mode_q <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs come straight from flops so the pins never glitch
   // Reset output reads high during reset, so parts outside see the
   // chip in reset from the very first moment
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         reset_out_pin <= reset_ctl_pkg::reset_out_reset_val;
      end
      else
      begin
         reset_out_pin <= core_reset_d;
      end
   end

   // Pull-up is forced on during power-on reset, before software can
   // set the disable bit
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         reset_pullup_en <= reset_ctl_pkg::pullup_reset_val;
      end
      else
      begin
         reset_pullup_en <= pullup_d;
      end
   end

   // Boot decision is recomputed every cycle, so securing the flash
   // later still forces internal boot
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         boot_external <= reset_ctl_pkg::boot_ext_reset_val;
      end
      else
      begin
         boot_external <= boot_ext_d;
      end
   end

   // Status word; core and debug resets both read asserted during
   // power-on reset; only it and the test-port reset clear the debug side
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         status <= reset_ctl_pkg::status_reset_val;
      end
      else
      begin
         status <= status_d;
      end
   end

endmodule

`default_nettype wire

// ### rtl/reset_ctl_pkg.sv
// Purpose: Shared constants and carrier types for the chip reset controller
// Assumes: One 10 MHz reference clock
// Notes: Release delay is a count of reference clock cycles
package reset_ctl_pkg;

   // Reference clock period in ns
   localparam int unsigned clk_period_ns = 100;
   // Internal reset release delay in clock cycles
   localparam logic [7:0] release_cycles = 8'h40;
   // Value of every control flop after reset
   localparam logic mode_reset_val = 1'b0;
   localparam logic [7:0] count_reset_val = 8'h00;
   // Value of every output after reset
   localparam logic reset_out_reset_val = 1'b1;
   localparam logic pullup_reset_val = 1'b1;
   localparam logic boot_ext_reset_val = 1'b0;

   // Boot mode after latching the selection pin
   typedef enum logic {boot_internal, boot_external} boot_mode_e;

   // Sequencer states
   typedef enum logic [1:0] {st_hold, st_count, st_run} seq_state_e;

   // Status that travels out of the block together
   typedef struct packed {
      logic core_reset;
      logic debug_reset;
      boot_mode_e boot_mode;
   } reset_status_s;

   // Status after reset: core and debug both held, internal boot
   localparam reset_status_s status_reset_val =
      '{1'b1, 1'b1, boot_internal};

endpackage

// ### tb/board_reset_model.sv
// Purpose: Board reset source and debugger reset
// Assumes: Requests change at the falling edge
// Notes: Full reset drives both pins together
`timescale 1ns/100ps
`default_nettype none
module board_reset_model
(
   input wire logic full_req,
   input wire logic core_req,
   output wire logic reset_pin_n,
   output wire logic test_reset_n
);
   // Core-only reset leaves the debugger reset idle
   assign reset_pin_n = !(full_req || core_req);
   assign test_reset_n = !full_req;
endmodule
`default_nettype wire

// ### tb/reset_pin_checker.sv
// Purpose: Port checks of the reset controller
// Assumes: ref_clk domain only
// Notes: Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module reset_pin_checker
(
   input wire logic ref_clk, rst, reset_pin_n, test_reset_n, boot_select_pin,
   input wire logic pullup_disable_reg, flash_secured, reset_out_pin,
   input wire logic reset_pullup_en, boot_external,
   input wire reset_ctl_pkg::reset_status_s status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   pin_hold_a: assert property (!reset_pin_n |=> reset_out_pin)
      else $error("out low under pin reset");
   out_mirror_a: assert property (reset_out_pin == status.core_reset)
      else $error("out differs from core reset");
   pullup_state_a: assert property (reset_pullup_en ==
      ($past(rst) || !$past(pullup_disable_reg)))
      else $error("pullup wrong");
   release_count_a: assert property ($fell(reset_out_pin) |->
      $past(reset_pin_n, 65) && (!$past(reset_pin_n, 66) || $past(rst, 66)))
      else $error("release count wrong");
   boot_latch_a: assert property ($rose(reset_pin_n) |=>
      boot_external == ($past(boot_select_pin) && !$past(flash_secured)))
      else $error("boot mode wrong");
   debug_keep_a: assert property (status.debug_reset ==
      ($past(rst) || !$past(test_reset_n)))
      else $error("debug reset wrong");
   por_hold_a: assert property ($fell(rst) |-> reset_out_pin [*8])
      else $error("out low after power-on");
   secure_boot_a: assert property (flash_secured |=> !boot_external)
      else $error("external boot while secured");
   run_stay_a: assert property (!reset_out_pin && reset_pin_n |=> !reset_out_pin)
      else $error("out rose without cause");
endmodule
bind chip_reset_pin_control reset_pin_checker i_chk(.ref_clk(ref_clk), .rst(rst),
   .reset_pin_n(reset_pin_n), .test_reset_n(test_reset_n),
   .boot_select_pin(boot_select_pin), .pullup_disable_reg(pullup_disable_reg),
   .flash_secured(flash_secured), .reset_out_pin(reset_out_pin),
   .reset_pullup_en(reset_pullup_en), .boot_external(boot_external),
   .status(status));
`default_nettype wire

// ### tb/tb_chip_reset_pin_control.sv
// Purpose: Random reset sequences with release count checks
// Assumes: Inputs change at the falling edge
// Notes: Fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s exp %b got %b", n, e, g); end end
module tb_chip_reset_pin_control;
   logic ref_clk = 0, rst = 1, full = 1, core = 0, bsel = 0, pud = 0, fsec = 0;
   wire logic pin_n, trst_n, out, pu, bext;
   reset_ctl_pkg::reset_status_s st;
   int err_count = 0, num_checks = 0, cyc = 0;
   board_reset_model i_brd(.full_req(full), .core_req(core),
      .reset_pin_n(pin_n), .test_reset_n(trst_n));
   chip_reset_pin_control i_dut(.ref_clk(ref_clk), .rst(rst),
      .reset_pin_n(pin_n), .test_reset_n(trst_n), .boot_select_pin(bsel),
      .pullup_disable_reg(pud), .flash_secured(fsec), .reset_out_pin(out),
      .reset_pullup_en(pu), .boot_external(bext), .status(st));
   function automatic logic exp_boot(logic s, logic f);
      return s & !f;
   endfunction
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial forever #50 ref_clk = ~ref_clk;
   // Hang guard: seven sequences need under a thousand cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 9000)
      begin
         err_count++;
         end_of_test;
      end
   end
   initial
   begin
      void'($urandom(32'h5F1FAD81));
      repeat (4) @(negedge ref_clk);
      rst = 0; full = 0; core = 1;
      for (int i = 0; i < 6; i++)
      begin
         @(negedge ref_clk);
         {bsel, fsec, pud} = 3'($urandom); full = i[0]; core = !i[0];
         if (i == 1) {bsel, fsec} = 2'b10;
         if (i == 3) {bsel, fsec} = 2'b11;
         repeat (2 + $urandom % 4) @(negedge ref_clk);
         `CHK("hold", 1'b1, out)
         `CHK("pullup", !pud, pu)
         `CHK("debug", !trst_n, st.debug_reset)
         full = 0; core = 0;
         if (i == 2)
         begin
            repeat (30) @(negedge ref_clk);
            core = 1; @(negedge ref_clk); core = 0;
         end
         repeat (64) @(negedge ref_clk);
         `CHK("count", 1'b1, out)
         @(negedge ref_clk);
         `CHK("release", 1'b0, out)
         `CHK("boot", exp_boot(bsel, fsec), bext)
         `CHK("mode", exp_boot(bsel, fsec), st.boot_mode)
         `CHK("core", 1'b0, st.core_reset)
         $display("test %0d done", i);
      end
      // Power-on reset in mid-run with the pin idle restarts the count
      rst = 1;
      pud = 1;
      repeat (2) @(negedge ref_clk);
      `CHK("por hold", 1'b1, out)
      `CHK("por pullup", 1'b1, pu)
      `CHK("por debug", 1'b1, st.debug_reset)
      rst = 0;
      repeat (64) @(negedge ref_clk);
      `CHK("por count", 1'b1, out)
      @(negedge ref_clk);
      `CHK("por release", 1'b0, out)
      `CHK("por pullup off", 1'b0, pu)
      `CHK("por boot", exp_boot(bsel, fsec), bext)
      $display("test por done");
      end_of_test;
   end
endmodule
`default_nettype wire
